// *** hw/rxs_writeback.sv ***
// Receive status descriptor write-back engine with APB registers and loopback
// Assumes a host memory port that acknowledges each request, and frame status
// from receive logic on the same clock
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "rxs_regs.svh"

module rxs_writeback
    import rxs_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         rx_frame_valid,
    input  wire rxs_frame_t   rx_frame,
    output logic              rx_frame_ready,
    input  wire logic         lb_frame_valid,
    input  wire rxs_frame_t   lb_frame,
    output logic              lb_frame_ready,
    input  wire logic [63:0]  sync_timer_counter,
    output rxs_mem_req_t      mem_req,
    input  wire logic         mem_ack,
    input  wire logic [31:0]  mem_rdata
);

    // Registers reached over APB
    logic [3:0]   ctrl_r;          // Enable, loopback, accept CRC, accept ICV
    logic [31:0]  ring_base_r;     // Address of descriptor 0
    logic [7:0]   ring_count_r;    // Descriptors in the ring
    logic [31:0]  sta_lo_r;        // Station address bits 31:0
    logic [15:0]  sta_hi_r;        // Station address bits 47:32
    logic [15:0]  frames_r;        // Delivered frame count
    logic [15:0]  drops_r;         // Frames dropped for CRC or ICV
    // Engine state
    rxs_state_t   state_r;         // Current state
    logic [7:0]   idx_r;           // Current descriptor index
    rxs_frame_t   frm_r;           // Frame being written back
    logic [63:0]  ts_r;            // Timestamp snapshot
    logic [11:0]  remain_r;        // Bytes not yet placed
    logic         first_r;         // Next descriptor holds first segment
    logic [2:0]   wr_idx_r;        // Word being written
    logic         ring_end_r;      // Fetched descriptor ends the ring
    logic [11:0]  bufsz_r;         // Fetched buffer size
    logic         rdy_r;           // Ready to take a frame
    logic [2:0]   words_done_r;    // Words written for this descriptor
    // Combinational helpers
    logic         take;            // A frame is taken this cycle
    rxs_frame_t   src_frame;       // Selected source frame
    logic         drop;            // Taken frame is not delivered
    logic         seg_last;        // Current segment ends the frame
    logic [11:0]  seg_len;         // Length placed in this descriptor
    logic         is_bcast;        // Destination is broadcast
    logic         is_mcast;        // Destination is group but not broadcast
    logic         is_ucast;        // Destination matches station address
    logic [31:0]  desc_addr;       // Address of current descriptor
    logic [31:0]  word_data;       // Data for word being written
    logic         apb_acc;         // APB access phase
    logic         apb_map;         // Address is mapped

    // Source selection: loopback routes transmit frames into receive logic
    assign src_frame = ctrl_r[`RXS_CTRL_LOOPBACK] ? lb_frame : rx_frame;
    assign take      = rdy_r && (ctrl_r[`RXS_CTRL_LOOPBACK] ? lb_frame_valid : rx_frame_valid);
    // Frames with unaccepted CRC or ICV errors are discarded
    assign drop = (src_frame.crc_err && !ctrl_r[`RXS_CTRL_ACC_CRC])
               || (src_frame.icv_err && !ctrl_r[`RXS_CTRL_ACC_ICV]);
    // Address classification of the held frame
    assign is_bcast = &frm_r.dest;
    assign is_mcast = frm_r.dest[0] && !is_bcast;
    assign is_ucast = frm_r.dest == {sta_hi_r, sta_lo_r};
    // Segment split against the host buffer size
    assign seg_last  = remain_r <= bufsz_r;
    assign seg_len   = seg_last ? remain_r : bufsz_r;
    assign desc_addr = ring_base_r + ({24'h0, idx_r} * `RXS_DESC_STRIDE);

    // Build the status word selected by wr_idx_r
    always_comb begin
        word_data = 32'h0000_0000;
        unique case (wr_idx_r)
            3'h1: word_data = ts_r[31:0];
            3'h2: word_data = ts_r[63:32];
            3'h3: word_data = {5'h00, frm_r.realign, frm_r.wakeup,
                               frm_r.decrypted, frm_r.agc, frm_r.antenna,
                               frm_r.rssi, frm_r.sq};
            3'h4: word_data = {frm_r.final_freq_offset, frm_r.received_power, frm_r.freq_offset_bias,
                               frm_r.snr, frm_r.mcsi};
            default: begin
                // Word 0: ownership left clear hands descriptor back
                word_data[`RXS_W0_OWN]      = 1'b0;
                word_data[`RXS_W0_RING_END] = ring_end_r;
                word_data[`RXS_W0_FIRST]    = first_r;
                word_data[`RXS_W0_LAST]     = seg_last;
                word_data[`RXS_W0_DMA_FAILURE]     = frm_r.dma_fail;
                word_data[`RXS_W0_FIFO_OVERFLOW]     = frm_r.overflow;
                word_data[`RXS_W0_SPRE]     = frm_r.short_pre;
                word_data[`RXS_W0_TR_SWITCH_STATE]     = frm_r.tr_switch_state;
                word_data[23:20]            = frm_r.rate;
                word_data[`RXS_W0_QOS]      = frm_r.qos;
                word_data[`RXS_W0_MCAST]    = is_mcast;
                word_data[`RXS_W0_UCAST]    = is_ucast;
                word_data[`RXS_W0_BCAST]    = is_bcast;
                word_data[`RXS_W0_RXERR]    = frm_r.rx_err && !frm_r.dma_fail;
                word_data[`RXS_W0_PWR]      = frm_r.pwr;
                word_data[`RXS_W0_CRC]      = frm_r.crc_err;
                word_data[`RXS_W0_ICV]      = frm_r.icv_err;
                // Non-final descriptors carry the segment length, the final one the
                // whole received length including CRC32
                word_data[11:0]             = seg_last ? frm_r.len : seg_len;
            end
        endcase
    end

    // Frame ready flags, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_r          <= 1'b0;
            rx_frame_ready <= 1'b0;
            lb_frame_ready <= 1'b0;
        end else begin
            rdy_r          <= ctrl_r[`RXS_CTRL_ENABLE] && state_r == ST_IDLE && !take;
            rx_frame_ready <= ctrl_r[`RXS_CTRL_ENABLE] && state_r == ST_IDLE && !take
                              && !ctrl_r[`RXS_CTRL_LOOPBACK];
            lb_frame_ready <= ctrl_r[`RXS_CTRL_ENABLE] && state_r == ST_IDLE && !take
                              && ctrl_r[`RXS_CTRL_LOOPBACK];
        end
    end

    // Descriptor engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r      <= ST_IDLE;
            idx_r        <= 8'h00;
            frm_r        <= '0;
            ts_r         <= 64'h0;
            remain_r     <= 12'h000;
            first_r      <= 1'b0;
            wr_idx_r     <= 3'h0;
            ring_end_r   <= 1'b0;
            bufsz_r      <= 12'h000;
            words_done_r <= 3'h0;
            mem_req      <= '0;
            frames_r     <= 16'h0000;
            drops_r      <= 16'h0000;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    // Take a frame; dropped ones never reach a descriptor
                    if (take && drop) begin
                        drops_r <= drops_r + 16'h0001;
                    end else if (take) begin
                        frm_r    <= src_frame;
                        ts_r     <= sync_timer_counter;
                        remain_r <= src_frame.len;
                        first_r  <= 1'b1;
                        state_r  <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    // Read word 0 of the current descriptor
                    if (!mem_req.valid) begin
                        mem_req <= '{valid: 1'b1, we: 1'b0, addr: desc_addr, wdata: 32'h0};
                    end else if (mem_ack) begin
                        mem_req    <= '0;
                        ring_end_r <= mem_rdata[`RXS_W0_RING_END];
                        bufsz_r    <= mem_rdata[11:0];
                        state_r    <= mem_rdata[`RXS_W0_OWN] ? ST_CHECK : ST_FETCH;
                    end
                end
                ST_CHECK: begin
                    // Engine owns the descriptor: on the last segment words 1 to 4 first, word 0 last; otherwise word 0 only
                    words_done_r <= 3'h0;
                    wr_idx_r     <= seg_last ? 3'h1 : 3'h0;
                    state_r      <= ST_WRITE;
                end
                ST_WRITE: begin
                    // Raise one write and hold it until the host acknowledges it
                    if (!mem_req.valid) begin
                        mem_req <= '{valid: 1'b1, we: 1'b1,
                                     addr: desc_addr + {27'h0, wr_idx_r, 2'b00},
                                     wdata: word_data};
                    end else if (mem_ack) begin
                        // Drop the request for a cycle so the host sees a clean gap
                        mem_req      <= '0;
                        words_done_r <= words_done_r + 3'h1;
                        if (wr_idx_r == 3'h0) begin
                            state_r <= ST_NEXT;
                        end else if (wr_idx_r == 3'h4) begin
                            wr_idx_r <= 3'h0;
                        end else begin
                            wr_idx_r <= wr_idx_r + 3'h1;
                        end
                    end
                end
                ST_NEXT: begin
                    // Advance pointer, wrapping at ring end or ring size
                    if (ring_end_r || idx_r + 8'h01 >= ring_count_r) begin
                        idx_r <= 8'h00;
                    end else begin
                        idx_r <= idx_r + 8'h01;
                    end
                    first_r  <= 1'b0;
                    remain_r <= remain_r - seg_len;
                    if (seg_last) begin
                        frames_r <= frames_r + 16'h0001;
                        state_r  <= ST_IDLE;
                    end else begin
                        state_r  <= ST_FETCH;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // APB slave: one wait state, answer on second cycle of access
    assign apb_acc = psel && penable && !pready;
    always_comb begin
        unique case (paddr)
            `RXS_CTRL_OFF, `RXS_RING_BASE_OFF, `RXS_RING_COUNT_OFF, `RXS_STA_LO_OFF,
            `RXS_STA_HI_OFF, `RXS_STATUS_OFF, `RXS_DROP_CNT_OFF: apb_map = 1'b1;
            default: apb_map = 1'b0;
        endcase
    end

    // APB answer and register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            prdata       <= 32'h0000_0000;
            ctrl_r       <= `RXS_CTRL_RST;
            ring_base_r  <= 32'h0000_0000;
            ring_count_r <= `RXS_RING_COUNT_RST;
            sta_lo_r     <= 32'h0000_0000;
            sta_hi_r     <= 16'h0000;
        end else begin
            pready  <= apb_acc;
            pslverr <= apb_acc && !apb_map;
            prdata  <= 32'h0000_0000;
            if (apb_acc && !pwrite) begin
                unique case (paddr)
                    `RXS_CTRL_OFF:       prdata <= {28'h0, ctrl_r};
                    `RXS_RING_BASE_OFF:  prdata <= ring_base_r;
                    `RXS_RING_COUNT_OFF: prdata <= {24'h0, ring_count_r};
                    `RXS_STA_LO_OFF:     prdata <= sta_lo_r;
                    `RXS_STA_HI_OFF:     prdata <= {16'h0, sta_hi_r};
                    `RXS_STATUS_OFF:     prdata <= {frames_r, idx_r, 5'h0, state_r};
                    `RXS_DROP_CNT_OFF:   prdata <= {16'h0, drops_r};
                    default:             prdata <= 32'h0000_0000;
                endcase
            end
            // Writes land on the edge that completes the transfer, with pready high;
            // the master still holds address and data there
            if (psel && penable && pready && pwrite) begin
                unique case (paddr)
                    `RXS_CTRL_OFF:       ctrl_r       <= pwdata[3:0];
                    `RXS_RING_BASE_OFF:  ring_base_r  <= pwdata;
                    `RXS_RING_COUNT_OFF: ring_count_r <= pwdata[7:0];
                    `RXS_STA_LO_OFF:     sta_lo_r     <= pwdata;
                    `RXS_STA_HI_OFF:     sta_hi_r     <= pwdata[15:0];
                    default:             ;
                endcase
            end
        end
    end

    // Checks on the write-back stream
    logic wr0;   // Word 0 write accepted
    assign wr0 = mem_req.valid && mem_req.we && mem_ack && mem_req.addr == desc_addr;

    AST_OWN_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        wr0 |-> !mem_req.wdata[`RXS_W0_OWN] ##1 state_r == ST_NEXT)
        else $error("word 0 written with ownership set");
    AST_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == ST_NEXT && ring_end_r) |=> idx_r == 8'h00)
        else $error("ring end did not wrap pointer");
    // Only the descriptor that holds the start of the frame is marked first;
    // nothing has been placed yet exactly when all bytes remain
    AST_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
        wr0 |-> mem_req.wdata[`RXS_W0_FIRST] == (remain_r == frm_r.len))
        else $error("first segment mark wrong");
    // The ending descriptor reports the whole frame length
    AST_LAST_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        (wr0 && mem_req.wdata[`RXS_W0_LAST]) |-> mem_req.wdata[11:0] == frm_r.len)
        else $error("length wrong in last descriptor");
    // Rate code passes through unchanged, reserved codes included
    AST_RATE: assert property (@(posedge pclk) disable iff (!presetn)
        wr0 |-> mem_req.wdata[23:20] == frm_r.rate)
        else $error("rate code altered");
    // In loopback the held frame is the one offered on the transmit side
    AST_LB_SRC: assert property (@(posedge pclk) disable iff (!presetn)
        (take && !drop && ctrl_r[`RXS_CTRL_LOOPBACK]) |=> frm_r == $past(lb_frame))
        else $error("loopback frame not routed to receive");
    AST_ERR_GATED: assert property (@(posedge pclk) disable iff (!presetn)
        wr0 |-> !(mem_req.wdata[`RXS_W0_DMA_FAILURE] && mem_req.wdata[`RXS_W0_RXERR]))
        else $error("receive error reported with failure");
    AST_BC_MC: assert property (@(posedge pclk) disable iff (!presetn)
        wr0 |-> !(mem_req.wdata[`RXS_W0_BCAST] && mem_req.wdata[`RXS_W0_MCAST]))
        else $error("broadcast and multicast both set");
    AST_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
        (wr0 && mem_req.wdata[`RXS_W0_LAST]) |-> words_done_r == 3'h4)
        else $error("ownership word not written last");
    AST_DROP: assert property (@(posedge pclk) disable iff (!presetn)
        (take && src_frame.crc_err && !ctrl_r[`RXS_CTRL_ACC_CRC]) |=> state_r == ST_IDLE && !rdy_r)
        else $error("CRC error frame delivered");
    AST_TS_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        (mem_req.valid && mem_req.we && mem_req.addr == desc_addr + 32'h4) |-> mem_req.wdata == ts_r[31:0])
        else $error("timestamp low half wrong");
    COV_LOOPBACK: cover property (@(posedge pclk) disable iff (!presetn)
        take && ctrl_r[`RXS_CTRL_LOOPBACK] ##[1:40] wr0);
    COV_MULTISEG: cover property (@(posedge pclk) disable iff (!presetn)
        wr0 && !mem_req.wdata[`RXS_W0_LAST]);
    COV_WRAP: cover property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_NEXT && ring_end_r);
    // A frame discarded for an unaccepted error
    COV_DROP: cover property (@(posedge pclk) disable iff (!presetn)
        take && drop);

endmodule // rxs_writeback

// *** hw/rxs_regs.svh ***
// Register offsets, control bits, descriptor field positions and reset values
// Assumes inclusion by the receive status write-back module only
`ifndef RXS_REGS_SVH
`define RXS_REGS_SVH
// APB register byte offsets
`define RXS_CTRL_OFF        8'h00
`define RXS_RING_BASE_OFF   8'h04
`define RXS_RING_COUNT_OFF  8'h08
`define RXS_STA_LO_OFF      8'h0c
`define RXS_STA_HI_OFF      8'h10
`define RXS_STATUS_OFF      8'h14
`define RXS_DROP_CNT_OFF    8'h18
// Control register bits
`define RXS_CTRL_ENABLE     0
`define RXS_CTRL_LOOPBACK   1
`define RXS_CTRL_ACC_CRC    2
`define RXS_CTRL_ACC_ICV    3
// Reset values
`define RXS_CTRL_RST        4'h0
`define RXS_RING_COUNT_RST  8'h04
// Descriptor stride in bytes and word 0 field positions
`define RXS_DESC_STRIDE     32'h0000_0020
`define RXS_W0_OWN          31
`define RXS_W0_RING_END     30
`define RXS_W0_FIRST        29
`define RXS_W0_LAST         28
`define RXS_W0_DMA_FAILURE         27
`define RXS_W0_FIFO_OVERFLOW         26
`define RXS_W0_SPRE         25
`define RXS_W0_TR_SWITCH_STATE         24
`define RXS_W0_QOS          19
`define RXS_W0_MCAST        18
`define RXS_W0_UCAST        17
`define RXS_W0_BCAST        16
`define RXS_W0_RXERR        15
`define RXS_W0_PWR          14
`define RXS_W0_CRC          13
`define RXS_W0_ICV          12
`endif

// *** hw/rxs_pkg.sv ***
// Types shared by the receive status descriptor write-back engine
// Assumes nothing beyond a SystemVerilog compiler
package rxs_pkg;
    // Status of one received frame from receive logic or the loopback path
    typedef struct packed {
        logic [11:0] len;          // Length in bytes including CRC32
        logic [47:0] dest;         // Destination address
        logic        dma_fail;     // Transfer to host failed
        logic        overflow;     // Receive FIFO ran dry of space
        logic        short_pre;    // Short preamble seen
        logic        tr_switch_state;         // T/R switch state
        logic [3:0]  rate;         // Receive rate code
        logic        qos;          // QoS frame
        logic        pwr;          // Power management bit in header
        logic        crc_err;      // CRC32 error
        logic        icv_err;      // ICV error
        logic        rx_err;       // Generic receive error
        logic        realign;      // Payload needs 4-byte realignment
        logic        wakeup;       // Unicast wakeup frame
        logic        decrypted;    // Frame was decrypted
        logic [7:0]  agc;          // Receive gain
        logic        antenna;      // Receiving antenna
        logic [6:0]  rssi;         // Signal strength
        logic [7:0]  sq;           // Signal quality
        logic [7:0]  final_freq_offset;          // Final frequency offset estimate
        logic [7:0]  received_power;         // Received power
        logic [5:0]  freq_offset_bias;     // Frequency offset bias
        logic [5:0]  snr;          // Long-training SNR
        logic [3:0]  mcsi;         // Masked subcarrier count
    } rxs_frame_t;
    // Host memory request
    typedef struct packed {
        logic        valid;        // Request pending
        logic        we;           // Write when high
        logic [31:0] addr;         // Byte address
        logic [31:0] wdata;        // Write data
    } rxs_mem_req_t;
    // Engine states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FETCH = 3'b001,
        ST_CHECK = 3'b010,
        ST_WRITE = 3'b011,
        ST_NEXT  = 3'b100
    } rxs_state_t;
endpackage

// *** verification/rxs_host_mem.sv ***
// Host memory model: a two-entry descriptor ring kept armed by the driver
// Assumes the engine keeps at most one memory request open at a time
`timescale 1ns/1ps
module rxs_host_mem
    import rxs_pkg::*;
(
    input  wire logic         pclk,
    input  wire rxs_mem_req_t mem_req,
    input  wire logic         slow,
    output logic              mem_ack,
    output logic [31:0]       mem_rdata
);
    logic [1:0]  wait_r; // Cycles stalled so far
    logic [31:0] cmd_w;  // Armed word 0: owned by engine, 64-byte buffer
    // Answer after 0 or 3 stalls; a released data bus shows the inverse
    always @(posedge pclk) begin
        cmd_w = mem_req.addr[5] ? 32'hc000_0040 : 32'h8000_0040;
        if (mem_req.valid && !mem_ack && wait_r == {slow, slow}) begin
            mem_ack   <= 1'b1;
            mem_rdata <= cmd_w;
            wait_r    <= 2'h0;
        end else begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_r    <= (mem_req.valid && !mem_ack) ? wait_r + 2'h1 : 2'h0;
        end
    end
    initial begin
        wait_r    = 2'h0;
        mem_ack   = 1'b0;
        mem_rdata = 32'h0;
    end
endmodule // rxs_host_mem

// *** verification/rx_status_descriptor_writeback_bench.sv ***
// Self-checking bench: APB set-up, frames from both sources, ring wrap
// Assumes the host memory model and the engine share one 10 MHz clock
`timescale 1ns/1ps
module rx_status_descriptor_writeback_bench
    import rxs_pkg::*;
;
    localparam logic [31:0] RB  = 32'h0000_1000;   // Ring base
    localparam logic [47:0] STA = 48'h0e02_0a0b_0c0e; // Station address
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
    logic rx_frame_valid, rx_frame_ready, lb_frame_valid, lb_frame_ready, mem_ack, idx;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, mem_rdata, lfsr;
    logic [63:0] ts, mq[$], aq[$];
    rxs_frame_t rx_frame, lb_frame, f;
    rxs_mem_req_t mem_req;
    int error_cnt, comparisons, i, k;
    rxs_writeback dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame), .rx_frame_ready(rx_frame_ready),
        .lb_frame_valid(lb_frame_valid), .lb_frame(lb_frame), .lb_frame_ready(lb_frame_ready),
        .sync_timer_counter(ts), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    rxs_host_mem u_mem (.pclk(pclk), .mem_req(mem_req), .slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    function automatic logic [31:0] nxt(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected word 0 of a written-back descriptor
    function automatic logic [31:0] w0(rxs_frame_t g, logic fs, logic ls, logic [11:0] n);
        return {1'b0, idx, fs, ls, g.dma_fail, g.overflow, g.short_pre, g.tr_switch_state, g.rate, g.qos,
            g.dest[0] & ~&g.dest, g.dest == STA, &g.dest, g.rx_err & ~g.dma_fail, g.pwr, g.crc_err, g.icv_err, n};
    endfunction
    task automatic check(string n, logic [63:0] s, logic [63:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    // Segments of 64 bytes; the last one carries words 1 to 4 first
    task automatic predict(rxs_frame_t g, logic [63:0] t);
        int rem;
        logic fs;
        rem = g.len;
        fs = 1'b1;
        while (rem > 64) begin
            mq.push_back({RB + {idx, 5'h0}, w0(g, fs, 1'b0, 12'h40)});
            idx ^= 1'b1;
            rem -= 64;
            fs = 1'b0;
        end
        mq.push_back({RB + {idx, 5'h4}, t[31:0]});
        mq.push_back({RB + {idx, 5'h8}, t[63:32]});
        mq.push_back({RB + {idx, 5'hc}, 5'h0, g.realign, g.wakeup, g.decrypted, g.agc, g.antenna, g.rssi, g.sq});
        mq.push_back({RB + {idx, 5'h10}, g.final_freq_offset, g.received_power, g.freq_offset_bias, g.snr, g.mcsi});
        mq.push_back({RB + {idx, 5'h0}, w0(g, fs, 1'b1, g.len)});
        idx ^= 1'b1;
    endtask
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        if (!wr) aq.push_back({31'h0, a > 8'h18, d});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic send(logic lb);
        ts <= {lfsr, nxt(lfsr)};
        rx_frame <= f;
        lb_frame <= f;
        rx_frame_valid <= !lb;
        lb_frame_valid <= lb;
        do @(posedge pclk); while ((lb ? lb_frame_ready : rx_frame_ready) !== 1'b1);
        rx_frame_valid <= 1'b0;
        lb_frame_valid <= 1'b0;
        repeat (2) @(posedge pclk);
        for (k = 0; k < 5000 && (mq.size() != 0 || (rx_frame_ready | lb_frame_ready) !== 1'b1); k++) @(posedge pclk);
    endtask
    // Compare each finished memory write and APB read with the oldest note
    always @(posedge pclk) begin
        if (mem_req.valid && mem_ack && mem_req.we)
            check("mem_write", {mem_req.addr, mem_req.wdata}, mq.size() ? mq.pop_front() : ~{mem_req.addr, mem_req.wdata});
        if (psel && penable && pready && !pwrite)
            check("apb_read", {31'h0, pslverr, prdata}, aq.pop_front());
    end
    task automatic end_of_test;
        error_cnt += mq.size() + aq.size();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #3_000_000;
        error_cnt++;
        end_of_test;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rx_frame_valid, lb_frame_valid, slow, idx} = '0;
        {rx_frame, lb_frame, ts, error_cnt, comparisons} = '0;
        lfsr = 32'h53a7;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        apb(1'b0, 8'h08, 32'h4);
        apb(1'b0, 8'h1c, 32'h0);
        apb(1'b1, 8'h04, RB);
        apb(1'b1, 8'h0c, STA[31:0]);
        apb(1'b1, 8'h10, {16'h0, STA[47:32]});
        apb(1'b1, 8'h00, 32'hd);
        for (i = 0; i < 17; i++) begin
            repeat (5) begin
                lfsr = nxt(lfsr);
                f = {f[99:0], lfsr};
            end
            f.len = (i < 2) ? 12'(64 << i) : 12'(lfsr[8:0]) + 12'h4;
            f.dest = (i % 4 == 0) ? STA : (i % 4 == 1) ? '1 : (i % 4 == 2) ? 48'h1 : {lfsr, 16'h2};
            f.rate = 4'(i);
            if (i == 15) apb(1'b1, 8'h00, 32'hf);
            if (i == 16) apb(1'b1, 8'h00, 32'h1);
            f.crc_err |= (i == 16);
            slow <= i[0];
            if (i < 16) predict(f, {lfsr, nxt(lfsr)});
            send(i == 15);
        end
        apb(1'b0, 8'h18, 32'h1);
        end_of_test;
    end
endmodule // rx_status_descriptor_writeback_bench
